// ### pcs_core.sv
// Program counter, return stack, status masking and data memory map.
`timescale 1ns/1ns
module pcs_core #(
	parameter int                 BANKS     = pcs_pkg::BANK_COUNT,
	parameter logic [14:0]        INT_VECTOR = 15'h0004
) (
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [31:0]        paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire pcs_pkg::pcs_instr_t instr,
	input  wire logic               wdt_timeout,
	input  wire logic               sleep_entry,
	output pcs_pkg::pcs_data_t      dout,
	output logic      [14:0]        pc,
	output logic                    stack_reset
);

	// ***************************************************************
	// State
	// ***************************************************************
	logic [14:0] pc_reg;
	logic [7:0]  status_reg;
	logic [7:0]  p0l_reg;
	logic [7:0]  p0h_reg;
	logic [7:0]  p1l_reg;
	logic [7:0]  p1h_reg;
	logic [5:0]  bank_reg;
	logic [7:0]  wacc_reg;
	logic [6:0]  latch_reg;
	logic [7:0]  intctl_reg;
	logic [4:0]  sp_reg;
	logic        ovf_reg;
	logic        unf_reg;
	logic        srst_en_reg;
	logic        stack_reset_reg;
	pcs_pkg::pcs_data_t dout_reg;
	logic [14:0] stack_mem [pcs_pkg::STK_DEPTH];
	logic [7:0]  gpr_mem [BANKS*pcs_pkg::GPR_BYTES];
	logic [7:0]  common_mem [pcs_pkg::COMMON_BYTES];

	// ***************************************************************
	// Address decoding
	// ***************************************************************
	function automatic pcs_pkg::pcs_region_t region(input logic [12:0] a);
		logic [6:0] off;
		logic [6:0] sfr_end;
		off = a[6:0];
		sfr_end = (a[12:7] >= 6'(pcs_pkg::SFR_BIG_BANK))
			? 7'(pcs_pkg::SFR_LARGE) : 7'(pcs_pkg::SFR_SMALL);
		if (off < pcs_pkg::CORE_END) begin
			return pcs_pkg::RG_CORE;
		end else if (off >= pcs_pkg::COMMON_BASE) begin
			return pcs_pkg::RG_COMMON;
		end else if (off < pcs_pkg::CORE_END + sfr_end) begin
			return pcs_pkg::RG_SFR;
		end else if (off >= pcs_pkg::GPR_BASE
			&& 32'(a[12:7]) < BANKS) begin
			return pcs_pkg::RG_GPR;
		end else begin
			return pcs_pkg::RG_NONE;
		end
	endfunction

	function automatic logic [7:0] core_read(input logic [5:0] idx);
		if (idx == pcs_pkg::IDX_PCL) begin
			return pc_reg[7:0];
		end else if (idx == pcs_pkg::IDX_STATUS) begin
			return status_reg;
		end else if (idx == pcs_pkg::IDX_P0L) begin
			return p0l_reg;
		end else if (idx == pcs_pkg::IDX_P0H) begin
			return p0h_reg;
		end else if (idx == pcs_pkg::IDX_P1L) begin
			return p1l_reg;
		end else if (idx == pcs_pkg::IDX_P1H) begin
			return p1h_reg;
		end else if (idx == pcs_pkg::IDX_BANK) begin
			return {2'b00, bank_reg};
		end else if (idx == pcs_pkg::IDX_WACC) begin
			return wacc_reg;
		end else if (idx == pcs_pkg::IDX_LATCH) begin
			return {1'b0, latch_reg};
		end else if (idx == pcs_pkg::IDX_INTCTL) begin
			return intctl_reg;
		end else begin
			return 8'h00;
		end
	endfunction

	// ***************************************************************
	// Instruction data access
	// ***************************************************************
	logic [15:0]  ptr0;
	logic [12:0]  daddr;
	logic         lin_hit;
	logic [15:0]  lin_off;
	pcs_pkg::pcs_region_t dreg;
	logic [31:0]  gpr_idx;
	logic         dwr;
	logic         core_wr;
	logic [5:0]   core_idx;
	logic [7:0]   drd;

	assign ptr0    = {p0h_reg, p0l_reg};
	assign lin_hit = instr.indirect && ptr0 >= pcs_pkg::LIN_BASE
		&& ptr0 <= pcs_pkg::LIN_LAST;
	assign lin_off = ptr0 - pcs_pkg::LIN_BASE;
	assign daddr   = instr.indirect ? ptr0[12:0]
		: {bank_reg, instr.faddr};
	assign dreg    = lin_hit ? pcs_pkg::RG_GPR
		: (instr.indirect && ptr0[15:13] != 3'b000) ? pcs_pkg::RG_NONE
		: region(daddr);
	assign gpr_idx = lin_hit ? 32'(lin_off)
		: 32'(daddr[12:7]) * pcs_pkg::GPR_BYTES
		+ 32'(daddr[6:0] - pcs_pkg::GPR_BASE);
	assign dwr      = instr.valid && instr.wr_en;
	assign core_idx = {2'b00, daddr[3:0]};
	assign core_wr  = dwr && dreg == pcs_pkg::RG_CORE
		&& core_idx > pcs_pkg::IDX_IND1;

	always_comb begin
		drd = 8'h00;
		if (dreg == pcs_pkg::RG_CORE) begin
			drd = core_read(core_idx);
		end else if (dreg == pcs_pkg::RG_GPR
			&& gpr_idx < 32'(BANKS * pcs_pkg::GPR_BYTES)) begin
			drd = gpr_mem[gpr_idx];
		end else if (dreg == pcs_pkg::RG_COMMON) begin
			drd = common_mem[daddr[3:0]];
		end
	end

	always_ff @(posedge pclk) begin
		if (dwr && dreg == pcs_pkg::RG_GPR
			&& gpr_idx < 32'(BANKS * pcs_pkg::GPR_BYTES)) begin
			gpr_mem[gpr_idx] <= instr.wdata;
		end
		if (dwr && dreg == pcs_pkg::RG_COMMON) begin
			common_mem[daddr[3:0]] <= instr.wdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dout_reg <= '0;
		end else begin
			dout_reg.rdata    <= (instr.valid && instr.rd_en) ? drd : 8'h00;
			dout_reg.sfr_hit  <= instr.valid && (instr.rd_en || instr.wr_en)
				&& dreg == pcs_pkg::RG_SFR;
			dout_reg.sfr_addr <= daddr;
		end
	end

	// ***************************************************************
	// APB decode
	// ***************************************************************
	logic        acc;
	logic        bwr;
	logic [5:0]  bidx;
	logic        bmap;

	assign acc   = psel && penable;
	assign bidx  = paddr[7:2];
	assign bmap  = paddr[31:8] == 24'h000000 && paddr[1:0] == 2'b00
		&& (bidx <= pcs_pkg::IDX_INTCTL
		|| (bidx >= pcs_pkg::IDX_SP && bidx <= pcs_pkg::IDX_CFG));
	assign bwr   = acc && pwrite && bmap;
	assign pready  = 1'b1;
	assign pslverr = acc && !bmap;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			if (paddr[7:2] == pcs_pkg::IDX_SP) begin
				prdata <= {27'h0000000, sp_reg};
			end else if (paddr[7:2] == pcs_pkg::IDX_STACK_TOP_LOW) begin
				prdata <= {24'h000000, stack_mem[sp_reg[3:0]][7:0]};
			end else if (paddr[7:2] == pcs_pkg::IDX_STACK_TOP_HIGH) begin
				prdata <= {25'h0000000, stack_mem[sp_reg[3:0]][14:8]};
			end else if (paddr[7:2] == pcs_pkg::IDX_PWRCTL) begin
				prdata <= {24'h000000, ovf_reg, unf_reg, 6'h00};
			end else if (paddr[7:2] == pcs_pkg::IDX_CFG) begin
				prdata <= {31'h00000000, srst_en_reg};
			end else begin
				prdata <= {24'h000000, core_read(paddr[7:2])};
			end
		end
	end

	// ***************************************************************
	// Stack control
	// ***************************************************************
	logic        push;
	logic        pop;
	logic        ovf;
	logic        unf;
	logic        srst;
	logic [4:0]  push_sp;
	logic [14:0] pc_inc;
	logic [14:0] pop_val;

	assign pc_inc = pc_reg + 15'h0001;
	assign push = instr.valid && (instr.op == pcs_pkg::OP_CALL
		|| instr.op == pcs_pkg::OP_RCALL
		|| instr.op == pcs_pkg::OP_INTV);
	assign pop  = instr.valid && (instr.op == pcs_pkg::OP_RET
		|| instr.op == pcs_pkg::OP_RETLIT
		|| instr.op == pcs_pkg::OP_IRET);
	assign ovf  = push && sp_reg >= pcs_pkg::SP_TOP
		&& sp_reg != pcs_pkg::SP_EMPTY;
	assign unf  = pop && sp_reg == pcs_pkg::SP_EMPTY;
	assign srst = srst_en_reg && (ovf || unf);
	assign push_sp = ovf ? 5'h00 : sp_reg + 5'h01;
	assign pop_val = unf ? stack_mem[pcs_pkg::STK_DEPTH-1]
		: stack_mem[sp_reg[3:0]];

	always_ff @(posedge pclk) begin
		if (push && !srst) begin
			stack_mem[push_sp[3:0]] <= instr.op == pcs_pkg::OP_INTV
				? pc_reg : pc_inc;
		end else if (bwr && bidx == pcs_pkg::IDX_STACK_TOP_LOW) begin
			stack_mem[sp_reg[3:0]][7:0] <= pwdata[7:0];
		end else if (bwr && bidx == pcs_pkg::IDX_STACK_TOP_HIGH) begin
			stack_mem[sp_reg[3:0]][14:8] <= pwdata[6:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sp_reg <= pcs_pkg::SP_EMPTY;
		end else if (srst) begin
			sp_reg <= pcs_pkg::SP_EMPTY;
		end else if (push) begin
			sp_reg <= push_sp;
		end else if (pop) begin
			sp_reg <= unf ? pcs_pkg::SP_UNF_WRAP : sp_reg - 5'h01;
		end else if (bwr && bidx == pcs_pkg::IDX_SP) begin
			sp_reg <= pwdata[4:0];
		end
	end

	// Hardware setting wins over a software clear in the same cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovf_reg         <= 1'b0;
			unf_reg         <= 1'b0;
			srst_en_reg     <= 1'b0;
			stack_reset_reg <= 1'b0;
		end else begin
			stack_reset_reg <= srst;
			if (bwr && bidx == pcs_pkg::IDX_CFG) begin
				srst_en_reg <= pwdata[0];
			end
			if (ovf) begin
				ovf_reg <= 1'b1;
			end else if (bwr && bidx == pcs_pkg::IDX_PWRCTL
				&& pwdata[pcs_pkg::PWR_OVF]) begin
				ovf_reg <= 1'b0;
			end
			if (unf) begin
				unf_reg <= 1'b1;
			end else if (bwr && bidx == pcs_pkg::IDX_PWRCTL
				&& pwdata[pcs_pkg::PWR_UNF]) begin
				unf_reg <= 1'b0;
			end
		end
	end

	// ***************************************************************
	// Program counter
	// ***************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_reg <= 15'h0000;
		end else if (srst) begin
			pc_reg <= 15'h0000;
		end else if (core_wr && core_idx == pcs_pkg::IDX_PCL) begin
			pc_reg <= {latch_reg, instr.wdata};
		end else if (instr.valid) begin
			case (instr.op)
				pcs_pkg::OP_STEP: begin
					pc_reg <= pc_inc;
				end
				pcs_pkg::OP_CALL: begin
					pc_reg <= {latch_reg[6:3], instr.operand};
				end
				pcs_pkg::OP_RCALL: begin
					pc_reg <= {latch_reg, wacc_reg};
				end
				pcs_pkg::OP_INTV: begin
					pc_reg <= INT_VECTOR;
				end
				pcs_pkg::OP_RET, pcs_pkg::OP_RETLIT, pcs_pkg::OP_IRET: begin
					pc_reg <= pop_val;
				end
				pcs_pkg::OP_RBRW: begin
					pc_reg <= pc_inc + {7'h00, wacc_reg};
				end
				pcs_pkg::OP_IBRA: begin
					pc_reg <= pc_inc
						+ {{6{instr.operand[8]}}, instr.operand[8:0]};
				end
				default: begin
					pc_reg <= pc_reg;
				end
			endcase
		end else if (bwr && bidx == pcs_pkg::IDX_PCL) begin
			pc_reg <= {latch_reg, pwdata[7:0]};
		end
	end

	// ***************************************************************
	// Core registers
	// ***************************************************************
	// An instruction write owns the cycle; a bus write to any core register
	// in that cycle is dropped, so the two data sources never mix.
	function automatic logic cw(input logic [5:0] idx);
		return core_wr ? core_idx == idx : (bwr && bidx == idx);
	endfunction

	logic [7:0] cdata;
	logic       st_lock;
	assign cdata   = core_wr ? instr.wdata : pwdata[7:0];
	assign st_lock = core_wr
		&& (instr.upd_z || instr.upd_dc || instr.upd_c);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			p0l_reg    <= 8'h00;
			p0h_reg    <= 8'h00;
			p1l_reg    <= 8'h00;
			p1h_reg    <= 8'h00;
			bank_reg   <= 6'h00;
			latch_reg  <= 7'h00;
			intctl_reg <= 8'h00;
			wacc_reg   <= 8'h00;
		end else begin
			if (cw(pcs_pkg::IDX_P0L)) p0l_reg <= cdata;
			if (cw(pcs_pkg::IDX_P0H)) p0h_reg <= cdata;
			if (cw(pcs_pkg::IDX_P1L)) p1l_reg <= cdata;
			if (cw(pcs_pkg::IDX_P1H)) p1h_reg <= cdata;
			if (cw(pcs_pkg::IDX_BANK)) bank_reg <= cdata[5:0];
			if (cw(pcs_pkg::IDX_LATCH)) latch_reg <= cdata[6:0];
			if (instr.valid && instr.op == pcs_pkg::OP_IRET) begin
				intctl_reg[pcs_pkg::INT_GIE] <= 1'b1;
			end else if (cw(pcs_pkg::IDX_INTCTL)) begin
				intctl_reg <= cdata;
			end
			if (instr.valid && instr.op == pcs_pkg::OP_RETLIT) begin
				wacc_reg <= instr.operand[7:0];
			end else if (cw(pcs_pkg::IDX_WACC)) begin
				wacc_reg <= cdata;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_reg <= pcs_pkg::STATUS_RST;
		end else begin
			if (cw(pcs_pkg::IDX_STATUS)) begin
				status_reg[7:5] <= cdata[7:5];
			end
			// A flag-updating instruction keeps its data off all three flags.
			if (cw(pcs_pkg::IDX_STATUS) && !st_lock) begin
				status_reg[pcs_pkg::ST_C]  <= cdata[pcs_pkg::ST_C];
				status_reg[pcs_pkg::ST_DC] <= cdata[pcs_pkg::ST_DC];
				status_reg[pcs_pkg::ST_Z]  <= cdata[pcs_pkg::ST_Z];
			end
			// Result flags override the data written to the same bits.
			if (instr.valid && instr.upd_z) begin
				status_reg[pcs_pkg::ST_Z] <= instr.res_zero;
			end
			if (instr.valid && instr.upd_dc) begin
				status_reg[pcs_pkg::ST_DC] <= instr.is_sub
					? !instr.res_dcarry : instr.res_dcarry;
			end
			if (instr.valid && instr.upd_c) begin
				status_reg[pcs_pkg::ST_C] <= instr.is_sub
					? !instr.res_carry : instr.res_carry;
			end
			// Only hardware events move the time-out and power-down bits.
			if (wdt_timeout) begin
				status_reg[pcs_pkg::ST_TO] <= 1'b0;
			end
			if (sleep_entry) begin
				status_reg[pcs_pkg::ST_PD] <= 1'b0;
			end
		end
	end

	assign pc          = pc_reg;
	assign dout        = dout_reg;
	assign stack_reset = stack_reset_reg;

endmodule // pcs_core

// ### pcs_pkg.sv
// Shared constants, types and register map of the program counter and stack.
package pcs_pkg;

	// ***************************************************************
	// Widths and sizes
	// ***************************************************************
	localparam int PC_W        = 15;
	localparam int STK_DEPTH   = 16;
	localparam int SP_W        = 5;
	localparam int BANK_COUNT  = 64;
	localparam int GPR_BYTES   = 80;
	localparam int COMMON_BYTES = 16;
	localparam int SFR_SMALL   = 20;
	localparam int SFR_LARGE   = 100;
	localparam int SFR_BIG_BANK = 60;

	// ***************************************************************
	// Register indices; the byte address is four times the index
	// ***************************************************************
	localparam logic [5:0] IDX_IND0   = 6'h00;
	localparam logic [5:0] IDX_IND1   = 6'h01;
	localparam logic [5:0] IDX_PCL    = 6'h02;
	localparam logic [5:0] IDX_STATUS = 6'h03;
	localparam logic [5:0] IDX_P0L    = 6'h04;
	localparam logic [5:0] IDX_P0H    = 6'h05;
	localparam logic [5:0] IDX_P1L    = 6'h06;
	localparam logic [5:0] IDX_P1H    = 6'h07;
	localparam logic [5:0] IDX_BANK   = 6'h08;
	localparam logic [5:0] IDX_WACC   = 6'h09;
	localparam logic [5:0] IDX_LATCH  = 6'h0a;
	localparam logic [5:0] IDX_INTCTL = 6'h0b;
	localparam logic [5:0] IDX_SP     = 6'h10;
	localparam logic [5:0] IDX_STACK_TOP_LOW   = 6'h11;
	localparam logic [5:0] IDX_STACK_TOP_HIGH   = 6'h12;
	localparam logic [5:0] IDX_PWRCTL = 6'h13;
	localparam logic [5:0] IDX_CFG    = 6'h14;

	// ***************************************************************
	// Field positions and reset values
	// ***************************************************************
	localparam int ST_C   = 0;
	localparam int ST_DC  = 1;
	localparam int ST_Z   = 2;
	localparam int ST_PD  = 3;
	localparam int ST_TO  = 4;
	localparam int PWR_OVF = 7;
	localparam int PWR_UNF = 6;
	localparam int INT_GIE = 7;
	localparam logic [7:0]      STATUS_RST = 8'h18;
	localparam logic [SP_W-1:0] SP_EMPTY   = 5'h1f;
	localparam logic [SP_W-1:0] SP_TOP     = 5'h0f;
	localparam logic [SP_W-1:0] SP_UNF_WRAP = 5'h0e;
	localparam logic [6:0] CORE_END    = 7'h0c;
	localparam logic [6:0] GPR_BASE    = 7'h20;
	localparam logic [6:0] COMMON_BASE = 7'h70;
	localparam logic [15:0] LIN_BASE   = 16'h2000;
	localparam logic [15:0] LIN_LAST   = 16'h2fef;

	// ***************************************************************
	// Operation kinds and carriers
	// ***************************************************************
	typedef enum logic [3:0] {
		OP_STEP   = 4'b0000,
		OP_CALL   = 4'b0001,
		OP_RCALL  = 4'b0010,
		OP_INTV   = 4'b0011,
		OP_RET    = 4'b0100,
		OP_RETLIT = 4'b0101,
		OP_IRET   = 4'b0110,
		OP_RBRW   = 4'b0111,
		OP_IBRA   = 4'b1000,
		OP_HOLD   = 4'b1001
	} pcs_op_t;

	typedef enum logic [2:0] {
		RG_CORE   = 3'b000,
		RG_SFR    = 3'b001,
		RG_GPR    = 3'b010,
		RG_COMMON = 3'b011,
		RG_NONE   = 3'b100
	} pcs_region_t;

	typedef struct packed {
		logic       valid;
		pcs_op_t    op;
		logic [10:0] operand;
		logic       rd_en;
		logic       wr_en;
		logic       indirect;
		logic [6:0] faddr;
		logic [7:0] wdata;
		logic       upd_z;
		logic       upd_dc;
		logic       upd_c;
		logic       is_sub;
		logic       res_zero;
		logic       res_carry;
		logic       res_dcarry;
	} pcs_instr_t;

	typedef struct packed {
		logic [7:0]  rdata;
		logic        sfr_hit;
		logic [12:0] sfr_addr;
	} pcs_data_t;

endpackage

// ### pcs_core_properties.sv
// Port-level assertions for the program counter and return stack core.
`timescale 1ns/1ns
module pcs_core_properties #(
	parameter logic [14:0] INT_VECTOR = 15'h0004
) (
	input wire logic                pclk,
	input wire logic                presetn,
	input wire logic                psel,
	input wire logic                penable,
	input wire logic                pwrite,
	input wire logic [31:0]         paddr,
	input wire logic [31:0]         pwdata,
	input wire logic [31:0]         prdata,
	input wire logic                pready,
	input wire logic                pslverr,
	input wire pcs_pkg::pcs_instr_t instr,
	input wire logic                wdt_timeout,
	input wire logic                sleep_entry,
	input wire pcs_pkg::pcs_data_t  dout,
	input wire logic [14:0]         pc,
	input wire logic                stack_reset
);
	// ***************************************************************
	// Helpers
	// ***************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic        go;
	logic [14:0] ofs;
	assign go = instr.valid && !instr.wr_en;
	assign ofs = {{6{instr.operand[8]}}, instr.operand[8:0]};

	// ***************************************************************
	// Assertions
	// ***************************************************************
	a_pc_step: assert property (go && instr.op == pcs_pkg::OP_STEP
		|=> pc == $past(pc) + 15'h1) else $error("pc did not step");
	a_call_target: assert property (go && instr.op == pcs_pkg::OP_CALL
		|=> pc[10:0] == $past(instr.operand) || pc == 15'h0)
		else $error("call target wrong");
	a_int_vector: assert property (go && instr.op == pcs_pkg::OP_INTV
		|=> pc == INT_VECTOR || pc == 15'h0) else $error("vector wrong");
	a_branch_signed: assert property (go && instr.op == pcs_pkg::OP_IBRA
		|=> pc == $past(pc) + 15'h1 + $past(ofs)) else $error("branch wrong");
	a_reset_clear: assert property ($rose(presetn) |-> pc == 15'h0)
		else $error("pc not cleared");
	a_reset_pulse: assert property (stack_reset |=> !stack_reset)
		else $error("stack reset pulse too long");
	a_unmapped_err: assert property (psel && penable && paddr == 32'h30
		|-> pslverr) else $error("no error on unmapped");
	a_mapped_ok: assert property (psel && penable && paddr == 32'h08
		|-> !pslverr) else $error("error on mapped");
	a_ready_high: assert property (psel && penable |-> pready)
		else $error("ready low in access");
	a_read_hold: assert property (!(psel && !penable && !pwrite)
		|=> $stable(prdata)) else $error("read data moved");
	a_idle_rdata: assert property (instr.valid && !instr.rd_en
		|=> dout.rdata == 8'h00) else $error("data without read");
	c_call: cover property (go && instr.op == pcs_pkg::OP_CALL);
	c_ret: cover property (go && instr.op == pcs_pkg::OP_RET);
	c_stk: cover property (stack_reset);
endmodule // pcs_core_properties

bind pcs_core pcs_core_properties #(.INT_VECTOR(INT_VECTOR)) i_pcs_core_properties (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .instr(instr),
	.wdt_timeout(wdt_timeout), .sleep_entry(sleep_entry), .dout(dout),
	.pc(pc), .stack_reset(stack_reset));

// ### pcs_core_tb.sv
// Self-checking bench of the program counter and return stack core.
`timescale 1ns/1ns
module pcs_core_tb;
	logic                pclk = 1'b0;
	logic                presetn = 1'b0;
	logic                psel = 1'b0;
	logic                penable = 1'b0;
	logic                pwrite = 1'b0;
	logic [31:0]         paddr = 32'h0;
	logic [31:0]         pwdata = 32'h0;
	logic [31:0]         prdata;
	logic                pready;
	logic                pslverr;
	pcs_pkg::pcs_instr_t instr = '0;
	pcs_pkg::pcs_instr_t t = '0;
	pcs_pkg::pcs_data_t  dout;
	logic [14:0]         pc;
	logic                stack_reset;
	logic                wdt = 1'b0;
	logic                slp = 1'b0;
	logic [8:0]          exp_q[$];
	logic [8:0]          e;
	logic [7:0]          r;
	logic [7:0]          l;
	logic [14:0]         p;
	logic [14:0]         q;
	int                  error_cnt = 0;
	int                  total_checks = 0;
	int                  cyc = 0;
	int                  seen = 0;
	int                  seed = 44;

	always #4 pclk = ~pclk;

	pcs_core i_pcs_core (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .instr(instr),
		.wdt_timeout(wdt), .sleep_entry(slp), .dout(dout), .pc(pc),
		.stack_reset(stack_reset));

	// ***************************************************************
	// Tasks
	// ***************************************************************
	task automatic stop_test();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string n, input logic [15:0] x,
		input logic [15:0] g);
		total_checks++;
		if (g !== x) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", n, x, g);
		end
	endtask

	task automatic cp(input logic [14:0] x);
		chk("pc", {1'b0, x}, {1'b0, pc});
	endtask

	// One APB transfer; a read notes its expected error flag and data.
	task automatic apb(input logic w, input logic [5:0] i,
		input logic [7:0] d, input logic [8:0] x);
		@(posedge pclk);
		if (!w)
			exp_q.push_back(x);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {24'h0, i, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [5:0] i, input logic [7:0] d);
		apb(1'b1, i, d, 9'h0);
	endtask

	task automatic rd(input logic [5:0] i, input logic [7:0] x);
		apb(1'b0, i, 8'h0, {1'b0, x});
	endtask

	task automatic send(input pcs_pkg::pcs_op_t o, input logic [10:0] a);
		t.valid = 1'b1;
		t.op = o;
		t.operand = a;
		@(posedge pclk);
		instr <= t;
		@(posedge pclk);
		instr <= '0;
		t = '0;
		#1;
	endtask

	task automatic st(input logic [7:0] d, input logic [3:0] f,
		input logic [7:0] x);
		t.wr_en = 1'b1;
		t.faddr = 7'h03;
		t.wdata = d;
		{t.upd_z, t.upd_dc, t.upd_c} = 3'b111;
		{t.is_sub, t.res_zero, t.res_carry, t.res_dcarry} = f;
		send(pcs_pkg::OP_STEP, 11'h0);
		rd(pcs_pkg::IDX_STATUS, x);
	endtask

	task automatic sf(input logic [7:0] b, input logic [6:0] f,
		input logic h);
		wr(pcs_pkg::IDX_BANK, b);
		t.rd_en = 1'b1;
		t.faddr = f;
		send(pcs_pkg::OP_STEP, 11'h0);
		chk("sfr hit", {15'h0, h}, {15'h0, dout.sfr_hit});
		if (h)
			chk("sfr addr", {3'h0, b[5:0], f}, {3'h0, dout.sfr_addr});
	endtask

	// ***************************************************************
	// Monitor and timeout
	// ***************************************************************
	always @(posedge pclk) begin
		cyc++;
		if (stack_reset === 1'b1)
			seen++;
		if (psel && penable && pready && !pwrite) begin
			e = exp_q.pop_front();
			chk("apb read", {7'h0, e}, {7'h0, pslverr, prdata[7:0]});
		end
		if (cyc == 5000) begin
			error_cnt++;
			stop_test();
		end
	end

	// ***************************************************************
	// Scenarios
	// ***************************************************************
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		#1 cp(15'h0);
		rd(pcs_pkg::IDX_SP, 8'h1f);
		r = 8'($random(seed));
		wr(pcs_pkg::IDX_STATUS, r);
		rd(pcs_pkg::IDX_STATUS, r | 8'h18);
		st(8'h00, 4'b0100, 8'h1c);
		st(8'hff, 4'b1010, 8'hfa);
		t.wr_en = 1'b1;
		t.faddr = 7'h03;
		t.wdata = 8'h07;
		t.upd_z = 1'b1;
		send(pcs_pkg::OP_STEP, 11'h0);
		rd(pcs_pkg::IDX_STATUS, 8'h1a);
		apb(1'b0, 6'h0c, 8'h0, 9'h100);
		l = 8'($random(seed)) & 8'h7f;
		r = 8'($random(seed));
		wr(pcs_pkg::IDX_LATCH, l);
		wr(pcs_pkg::IDX_PCL, r);
		p = {l[6:0], r};
		#1 cp(p);
		rd(pcs_pkg::IDX_PCL, r);
		send(pcs_pkg::OP_CALL, 11'h5a5);
		cp({l[6:3], 11'h5a5});
		p = p + 15'h1;
		rd(pcs_pkg::IDX_SP, 8'h00);
		rd(pcs_pkg::IDX_STACK_TOP_LOW, p[7:0]);
		rd(pcs_pkg::IDX_STACK_TOP_HIGH, {1'b0, p[14:8]});
		rd(pcs_pkg::IDX_LATCH, l);
		send(pcs_pkg::OP_RET, 11'h0);
		cp(p);
		rd(pcs_pkg::IDX_SP, 8'h1f);
		r = 8'($random(seed));
		wr(pcs_pkg::IDX_WACC, r);
		send(pcs_pkg::OP_RCALL, 11'h0);
		q = p + 15'h1;
		p = {l[6:0], r};
		cp(p);
		send(pcs_pkg::OP_RBRW, 11'h0);
		p = p + 15'h1 + {7'h0, r};
		cp(p);
		send(pcs_pkg::OP_IBRA, 11'h1f0);
		p = p + 15'h1 - 15'h10;
		cp(p);
		send(pcs_pkg::OP_INTV, 11'h0);
		cp(15'h0004);
		send(pcs_pkg::OP_IRET, 11'h0);
		cp(p);
		rd(pcs_pkg::IDX_INTCTL, 8'h80);
		send(pcs_pkg::OP_RETLIT, 11'h03c);
		cp(q);
		rd(pcs_pkg::IDX_WACC, 8'h3c);
		send(pcs_pkg::OP_HOLD, 11'h0);
		cp(q);
		wr(pcs_pkg::IDX_LATCH, 8'h00);
		for (int k = 0; k < 17; k++)
			send(pcs_pkg::OP_CALL, 11'h100 + 11'(k));
		rd(pcs_pkg::IDX_PWRCTL, 8'h80);
		rd(pcs_pkg::IDX_SP, 8'h00);
		rd(pcs_pkg::IDX_STACK_TOP_LOW, 8'h10);
		wr(pcs_pkg::IDX_SP, 8'h01);
		rd(pcs_pkg::IDX_STACK_TOP_LOW, 8'h01);
		wr(pcs_pkg::IDX_PWRCTL, 8'h80);
		wr(pcs_pkg::IDX_SP, 8'h1f);
		send(pcs_pkg::OP_RET, 11'h0);
		cp(15'h010f);
		rd(pcs_pkg::IDX_PWRCTL, 8'h40);
		rd(pcs_pkg::IDX_SP, 8'h0e);
		wr(pcs_pkg::IDX_PWRCTL, 8'h40);
		wr(pcs_pkg::IDX_CFG, 8'h01);
		wr(pcs_pkg::IDX_SP, 8'h0f);
		send(pcs_pkg::OP_CALL, 11'h123);
		cp(15'h0);
		rd(pcs_pkg::IDX_SP, 8'h1f);
		rd(pcs_pkg::IDX_PWRCTL, 8'h80);
		chk("stack reset", 16'h1, 16'(seen));
		sf(8'h03, 7'h0c, 1'b1);
		sf(8'h03, 7'h1f, 1'b1);
		sf(8'h03, 7'h20, 1'b0);
		sf(8'h3c, 7'h6f, 1'b1);
		sf(8'h3c, 7'h70, 1'b0);
		t.wr_en = 1'b1;
		t.faddr = 7'h70;
		t.wdata = r;
		send(pcs_pkg::OP_STEP, 11'h0);
		wr(pcs_pkg::IDX_BANK, 8'h09);
		t.rd_en = 1'b1;
		t.faddr = 7'h70;
		send(pcs_pkg::OP_STEP, 11'h0);
		chk("common", {8'h0, r}, {8'h0, dout.rdata});
		wr(pcs_pkg::IDX_P0H, 8'h20);
		wr(pcs_pkg::IDX_P0L, 8'h50);
		wr(pcs_pkg::IDX_BANK, 8'h01);
		t.wr_en = 1'b1;
		t.indirect = 1'b1;
		t.wdata = ~r;
		send(pcs_pkg::OP_STEP, 11'h0);
		t.rd_en = 1'b1;
		t.faddr = 7'h20;
		send(pcs_pkg::OP_STEP, 11'h0);
		chk("linear", {8'h0, ~r}, {8'h0, dout.rdata});
		@(posedge pclk);
		wdt <= 1'b1;
		slp <= 1'b1;
		@(posedge pclk);
		wdt <= 1'b0;
		slp <= 1'b0;
		wr(pcs_pkg::IDX_STATUS, 8'hff);
		rd(pcs_pkg::IDX_STATUS, 8'he7);
		stop_test();
	end
endmodule // pcs_core_tb
